// ---- testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_fail++; $display("unexpected at %0t: %h %h", $time, a, e); end end
module testbench;
  import une_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic we_i = 1'b0;
  logic re_i = 1'b0;
  logic ce_i = 1'b1;
  wire logic tok_out_i, tok_in_i, tok_ping_i, rx_valid_i, rx_end_i, rx_err_i, rx_pid1_i, tx_ready_i, hs_ack_i, hs_tmo_i;
  wire logic [7:0] rx_data_i, tx_data_o;
  wire logic resp_stb_o, resp_pid1_o, tx_valid_o, tx_last_o;
  wire logic [31:0] rdata_o;
  wire logic [STAT_W-1:0] stat_o;
  une_resp_type resp_code_o;
  logic [31:0] rv;
  logic [7:0] exp[$];
  int n_fail = 0;
  int checks = 0;
  int n;
  always #4 mclk_i = ~mclk_i;
  une_engine #(.DEPTH(1024)) uut (.*);
  une_host_model host (.mclk_i(mclk_i), .tok_out_o(tok_out_i), .tok_in_o(tok_in_i), .tok_ping_o(tok_ping_i),
    .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i), .rx_end_o(rx_end_i), .rx_err_o(rx_err_i), .rx_pid1_o(rx_pid1_i),
    .tx_ready_o(tx_ready_i), .hs_ack_o(hs_ack_i), .hs_tmo_o(hs_tmo_i), .resp_stb_i(resp_stb_o),
    .resp_code_i(resp_code_o), .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o), .tx_last_i(tx_last_o));
  function automatic logic [31:0] cfgv(logic [1:0] t, logic d, logic im, logic h, logic nk, logic [10:0] mps);
    return {5'h00, mps, 10'h000, nk, h, im, d, t};
  endfunction : cfgv
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    we_i <= 1'b1;
    @(posedge mclk_i);
    we_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge mclk_i);
    addr_i <= a;
    re_i <= 1'b1;
    @(posedge mclk_i);
    re_i <= 1'b0;
    #1 rv = rdata_o;
  endtask : rd
  task automatic st(input int b, input logic e);
    rd(ADDR_STAT);
    `CHK(rv[b], e);
  endtask : st
  task automatic av(input int e);
    rd(ADDR_AVAIL);
    `CHK(rv, 32'(e));
  endtask : av
  task automatic tg(input logic e);
    rd(ADDR_CFG);
    `CHK(rv[CFG_TGL_BIT], e);
  endtask : tg
  task automatic fill(input int k);
    exp.delete();
    host.got.delete();
    for (int i = 0; i < k; i++)
    begin
      exp.push_back(8'($urandom));
      wr(ADDR_DATA, {24'h0, exp[i]});
    end
  endtask : fill
  task automatic same(input int reps);
    `CHK(host.got.size(), reps * exp.size());
    foreach (host.got[i]) `CHK(host.got[i], exp[i % exp.size()]);
  endtask : same
  task automatic print_verdict();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    void'($urandom(27329));
    repeat (10) @(posedge mclk_i);
    rst_i <= 1'b0;
    rd(ADDR_CFG);
    `CHK(rv, CFG_RESET);
    rd(8'h14);
    `CHK(rv, 32'h0);
    for (int k = 1; k < 3; k++)
    begin
      wr(ADDR_CFG, cfgv(2'(k), 0, 0, 0, 0, 64));
      wr(ADDR_STAT, 32'h7FF);
      host.sent.delete();
      host.out_pkt(5, 0, 0);
      `CHK(host.rsp, RSP_ACK);
      st(ST_OUT_TOK, 1);
      av(5);
      for (int i = 0; i < 5; i++)
      begin
        rd(ADDR_DATA);
        `CHK(rv[7:0], host.sent[i]);
      end
      host.out_pkt(3, 0, 0);
      av(0);
      tg(1);
      $display("OUT test %0d done", k);
    end
    wr(ADDR_CFG, cfgv(EPT_INTR, 0, 1, 0, 0, 64));
    host.out_pkt(2, 0, 1);
    tg(1);
    host.out_pkt(2, 0, 1);
    tg(0);
    n = host.n_rsp;
    host.ping();
    `CHK(host.n_rsp, n);
    wr(ADDR_CFG, cfgv(EPT_INTR, 0, 0, 1, 0, 64));
    host.out_pkt(3, 0, 0);
    `CHK(host.rsp, RSP_STALL);
    av(0);
    $display("interrupt OUT test done");
    // Fill until refused; the level expected is the sum of the accepted packets
    wr(ADDR_CFG, cfgv(EPT_BULK, 0, 0, 0, 0, 512));
    // Bulk OUT with an empty buffer has room for a full packet, so PING gets ACK
    host.ping();
    `CHK(host.rsp, RSP_ACK);
    n = 0;
    for (int i = 0; i < 4 && host.rsp != RSP_NAK; i++)
    begin
      wr(ADDR_STAT, 32'h7FF);
      host.out_pkt(512, 0, i[0]);
      n += host.rsp == RSP_ACK ? 512 : 0;
    end
    `CHK(host.rsp, RSP_NAK);
    st(ST_OUT_NAK, 1);
    st(ST_PKT_RX, 0);
    av(n);
    $display("full test done");
    wr(ADDR_CFG, cfgv(EPT_ISO, 0, 0, 1, 0, 16));
    n = host.n_rsp;
    host.out_pkt(6, 0, 0);
    st(ST_OUT_ACK, 1);
    host.out_pkt(6, 1, 0);
    `CHK(host.n_rsp, n);
    st(ST_TIMEOUT, 1);
    av(12);
    wr(ADDR_CFG, cfgv(EPT_ISO, 0, 0, 0, 1, 16));
    host.out_pkt(4, 0, 0);
    st(ST_OVERFLOW, 1);
    av(0);
    $display("iso OUT test done");
    wr(ADDR_CFG, cfgv(EPT_BULK, 1, 0, 0, 0, 8));
    fill(3);
    host.in_pkt(0);
    `CHK(host.rsp, RSP_NAK);
    st(ST_IN_TOK, 1);
    wr(ADDR_XFER, 32'h0);
    host.in_pkt(2);
    wr(ADDR_STAT, 32'h7FF);
    tg(0);
    host.in_pkt(1);
    same(2);
    st(ST_PKT_TX, 1);
    tg(1);
    wr(ADDR_XFER, 32'h0);
    host.in_pkt(1);
    `CHK(host.rsp, RSP_ZLP);
    `CHK(resp_pid1_o, 1'b1);
    wr(ADDR_CFG, cfgv(EPT_BULK, 1, 0, 1, 0, 8));
    host.in_pkt(0);
    `CHK(host.rsp, RSP_STALL);
    $display("bulk IN test done");
    wr(ADDR_CFG, cfgv(EPT_ISO, 1, 0, 1, 0, 4));
    wr(ADDR_STAT, 32'h7FF);
    host.in_pkt(0);
    `CHK(host.rsp, RSP_ZLP);
    st(ST_IN_NAK, 1);
    st(ST_UNDERFLOW, 1);
    fill(4);
    host.in_pkt(0);
    same(1);
    st(ST_IN_ACK, 1);
    // Enable low freezes the block, so this clearing write must not land
    @(posedge mclk_i);
    ce_i <= 1'b0;
    wr(ADDR_STAT, 32'h7FF);
    ce_i <= 1'b1;
    st(ST_IN_ACK, 1);
    wr(ADDR_CFG, cfgv(EPT_INTR, 1, 1, 0, 0, 8));
    fill(2);
    wr(ADDR_XFER, 32'h0);
    host.in_pkt(2);
    tg(1);
    $display("iso and interrupt IN test done");
    print_verdict();
  end
  // Tests take some two thousand cycles; the 60000-cycle limit leaves a wide margin
  initial
  begin
    #(8 * 60000);
    n_fail++;
    print_verdict();
  end
endmodule : testbench
`default_nettype wire

// ---- une_engine.sv ----
`timescale 1ns/100ps
`default_nettype none
module une_engine #(
  parameter int DEPTH = 2048
) (
  // Clock, enable and reset
  input wire logic mclk_i,
  input wire logic ce_i,
  input wire logic rst_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [31:0] rdata_o,
  // Token and receive side
  input wire logic tok_out_i,
  input wire logic tok_in_i,
  input wire logic tok_ping_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_end_i,
  input wire logic rx_err_i,
  input wire logic rx_pid1_i,
  // Answer and transmit side
  output logic resp_stb_o,
  output var une_pkg::une_resp_type resp_code_o,
  output logic resp_pid1_o,
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  output logic tx_last_o,
  input wire logic tx_ready_i,
  input wire logic hs_ack_i,
  input wire logic hs_tmo_i,
  // Endpoint status
  output logic [une_pkg::STAT_W-1:0] stat_o
);
  import une_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int PW = AW + 1;
  localparam logic [PW-1:0] DEP = PW'(DEPTH);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [PW-1:0] pmin(input logic [PW-1:0] a, input logic [PW-1:0] b);
    pmin = (a < b) ? a : b;
  endfunction : pmin

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction : hit

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [7:0] mem [DEPTH];
  logic [31:0] cfg_reg;
  logic [STAT_W-1:0] ev_reg;
  logic [XFER_W-1:0] xfer_reg;
  logic [PW-1:0] bnd_reg;
  logic [PW-1:0] lcl_reg;
  logic [PW-1:0] upt_reg;
  logic [PW-1:0] len_reg;
  logic [PW-1:0] cnt_reg;
  logic [PW-1:0] vcnt_reg;
  logic [PW-1:0] sent_reg;
  logic vld_reg;
  logic in_ok_reg;
  logic tgl_reg;
  logic drop_reg;
  logic stall_reg;
  une_state_type state_reg;

  logic [1:0] ep_type;
  logic dir_in;
  logic is_iso;
  logic int_tgl;
  logic halt_eff;
  logic [PW-1:0] mps;
  logic [PW-1:0] lvl;
  logic cfg_wr;
  logic usb_we;
  logic lcl_we;
  logic lcl_re;

  always_comb
  begin
    ep_type = cfg_reg[CFG_TYPE_LSB +: 2];
    dir_in = cfg_reg[CFG_DIR_BIT];
    is_iso = (ep_type == EPT_ISO);
    int_tgl = (ep_type == EPT_INTR) && cfg_reg[CFG_IMODE_BIT];
    halt_eff = cfg_reg[CFG_HALT_BIT] && !is_iso;
    mps = PW'(cfg_reg[CFG_MPS_LSB +: MPS_W]);
    lvl = dir_in ? (lcl_reg - bnd_reg) : (bnd_reg - lcl_reg);
    cfg_wr = we_i && hit(addr_i, ADDR_CFG);
    // Bytes land only while room remains; excess marks the packet as dropped
    usb_we = (state_reg == S_RX) && rx_valid_i && !drop_reg && ((upt_reg - lcl_reg) != DEP);
    lcl_we = we_i && hit(addr_i, ADDR_DATA) && dir_in && (lvl != DEP);
    // Only committed packets are readable, so a packet in flight stays hidden
    lcl_re = re_i && hit(addr_i, ADDR_DATA) && !dir_in && (lvl != '0);
  end

  // ----------------------------------------
  // Packet buffer
  // ----------------------------------------
  // One buffer shared by both sides: local and USB sides use separate pointers
  always_ff @(posedge mclk_i)
  begin
    if (ce_i && usb_we)
      mem[upt_reg[AW-1:0]] <= rx_data_i;
    else if (ce_i && lcl_we)
      mem[lcl_reg[AW-1:0]] <= wdata_i[7:0];
  end

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      cfg_reg <= CFG_RESET;
    else if (ce_i && cfg_wr)
      cfg_reg <= wdata_i;
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      rdata_o <= 32'h0000_0000;
    else if (ce_i)
    begin
      rdata_o <= 32'h0000_0000;
      if (re_i)
      begin
        case (addr_i)
          ADDR_CFG: rdata_o <= {cfg_reg[31:CFG_TGL_BIT+1], tgl_reg, cfg_reg[CFG_TGL_BIT-1:0]};
          ADDR_STAT: rdata_o <= 32'(stat_o);
          ADDR_XFER: rdata_o <= 32'(xfer_reg);
          ADDR_AVAIL: rdata_o <= 32'(lvl);
          ADDR_DATA: rdata_o <= lcl_re ? {24'h00_0000, mem[lcl_reg[AW-1:0]]} : 32'h0000_0000;
          default: rdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Local pointer: write pointer for IN, read pointer for OUT
  always_ff @(posedge mclk_i)
  begin
    if (rst_i || (ce_i && cfg_wr))
      lcl_reg <= '0;
    else if (ce_i && (lcl_we || lcl_re))
      lcl_reg <= lcl_reg + PW'(1);
  end

  // ----------------------------------------
  // Status bits
  // ----------------------------------------
  // Set wins over a clear in the same cycle
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      stat_o <= '0;
    else if (ce_i)
    begin
      if (we_i && hit(addr_i, ADDR_STAT))
        stat_o <= (stat_o & ~wdata_i[STAT_W-1:0]) | ev_reg;
      else
        stat_o <= stat_o | ev_reg;
    end
  end

  // ----------------------------------------
  // IN validation
  // ----------------------------------------
  always_ff @(posedge mclk_i)
  begin
    if (rst_i || (ce_i && cfg_wr))
    begin
      xfer_reg <= '0;
      vld_reg <= 1'b0;
      vcnt_reg <= '0;
    end
    else if (ce_i)
    begin
      if (we_i && hit(addr_i, ADDR_XFER))
      begin
        if (wdata_i[XFER_W-1:0] == '0)
        begin
          vld_reg <= 1'b1;
          vcnt_reg <= lvl;
        end
        xfer_reg <= wdata_i[XFER_W-1:0];
      end
      else if (lcl_we && xfer_reg != '0)
      begin
        xfer_reg <= xfer_reg - XFER_W'(1);
        if (xfer_reg == XFER_W'(1))
        begin
          vld_reg <= 1'b1;
          vcnt_reg <= lvl + PW'(1);
        end
      end
      else if (in_ok_reg)
      begin
        // A full last packet keeps the flag so a zero-length packet follows
        vcnt_reg <= (vcnt_reg > sent_reg) ? vcnt_reg - sent_reg : '0;
        if (vcnt_reg <= sent_reg && sent_reg < mps)
          vld_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Transaction engine
  // ----------------------------------------
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      state_reg <= S_IDLE;
      ev_reg <= '0;
      upt_reg <= '0;
      bnd_reg <= '0;
      len_reg <= '0;
      cnt_reg <= '0;
      sent_reg <= '0;
      in_ok_reg <= 1'b0;
      tgl_reg <= 1'b0;
      drop_reg <= 1'b0;
      stall_reg <= 1'b0;
      resp_stb_o <= 1'b0;
      resp_code_o <= RSP_ACK;
      resp_pid1_o <= 1'b0;
      tx_valid_o <= 1'b0;
      tx_data_o <= 8'h00;
      tx_last_o <= 1'b0;
    end
    else if (ce_i)
    begin
      ev_reg <= '0;
      resp_stb_o <= 1'b0;
      in_ok_reg <= 1'b0;
      if (cfg_wr)
      begin
        // Reconfiguring restarts the endpoint with DATA0 and an empty buffer
        state_reg <= S_IDLE;
        tgl_reg <= 1'b0;
        bnd_reg <= '0;
        upt_reg <= '0;
        tx_valid_o <= 1'b0;
      end
      else
      begin
        case (state_reg)
          S_IDLE:
          begin
            if (tok_out_i && !dir_in)
            begin
              ev_reg[ST_OUT_TOK] <= 1'b1;
              upt_reg <= bnd_reg;
              stall_reg <= halt_eff;
              drop_reg <= halt_eff || cfg_reg[CFG_NAKO_BIT] || ((bnd_reg - lcl_reg) == DEP);
              state_reg <= S_RX;
            end
            else if (tok_ping_i && !dir_in && ep_type == EPT_BULK)
            begin
              resp_stb_o <= 1'b1;
              if (halt_eff)
                resp_code_o <= RSP_STALL;
              else if (cfg_reg[CFG_NAKO_BIT] || (DEP - lvl) < mps)
                resp_code_o <= RSP_NAK;
              else
                resp_code_o <= RSP_ACK;
            end
            else if (tok_in_i && dir_in)
            begin
              ev_reg[ST_IN_TOK] <= 1'b1;
              upt_reg <= bnd_reg;
              cnt_reg <= '0;
              resp_stb_o <= 1'b1;
              resp_pid1_o <= is_iso ? 1'b0 : tgl_reg;
              if (halt_eff)
                resp_code_o <= RSP_STALL;
              else if (lvl >= mps || (vld_reg && lvl != '0))
              begin
                len_reg <= (lvl >= mps) ? mps : pmin(vcnt_reg, lvl);
                resp_code_o <= RSP_DATA;
                state_reg <= S_TX;
              end
              else if (vld_reg)
              begin
                len_reg <= '0;
                resp_code_o <= RSP_ZLP;
                state_reg <= S_TXW;
                if (is_iso)
                begin
                  ev_reg[ST_PKT_TX] <= 1'b1;
                  ev_reg[ST_IN_ACK] <= 1'b1;
                  in_ok_reg <= 1'b1;
                  sent_reg <= '0;
                  state_reg <= S_IDLE;
                end
              end
              else if (is_iso)
              begin
                // Nothing validated: an empty packet still goes out on time
                resp_code_o <= RSP_ZLP;
                ev_reg[ST_IN_NAK] <= 1'b1;
                ev_reg[ST_UNDERFLOW] <= 1'b1;
                ev_reg[ST_PKT_TX] <= 1'b1;
              end
              else
              begin
                resp_code_o <= RSP_NAK;
                ev_reg[ST_IN_NAK] <= 1'b1;
              end
            end
          end
          S_RX:
          begin
            if (usb_we)
              upt_reg <= upt_reg + PW'(1);
            else if (rx_valid_i && !drop_reg)
              drop_reg <= 1'b1;
            if (rx_end_i)
            begin
              state_reg <= S_IDLE;
              if (is_iso)
              begin
                // No handshake on iso; software judges from the status bits
                if (drop_reg)
                  ev_reg[ST_OVERFLOW] <= 1'b1;
                else
                begin
                  bnd_reg <= upt_reg;
                  ev_reg[ST_PKT_RX] <= 1'b1;
                  ev_reg[ST_TIMEOUT] <= rx_err_i;
                  ev_reg[ST_OUT_ACK] <= !rx_err_i;
                end
              end
              else if (stall_reg)
              begin
                resp_stb_o <= 1'b1;
                resp_code_o <= RSP_STALL;
              end
              else
              begin
                if (int_tgl)
                  tgl_reg <= !tgl_reg;
                if (rx_err_i)
                  ev_reg[ST_TIMEOUT] <= 1'b1;
                else if (drop_reg)
                begin
                  resp_stb_o <= 1'b1;
                  resp_code_o <= RSP_NAK;
                  ev_reg[ST_OUT_NAK] <= 1'b1;
                end
                else
                begin
                  resp_stb_o <= 1'b1;
                  resp_code_o <= RSP_ACK;
                  ev_reg[ST_OUT_ACK] <= 1'b1;
                  // Outside interrupt toggle mode, a repeated packet with the old toggle is acknowledged, not stored
                  if (int_tgl || rx_pid1_i == tgl_reg)
                  begin
                    bnd_reg <= upt_reg;
                    ev_reg[ST_PKT_RX] <= 1'b1;
                    if (!int_tgl)
                      tgl_reg <= !tgl_reg;
                  end
                end
              end
            end
          end
          S_TX:
          begin
            if (!tx_valid_o || tx_ready_i)
            begin
              if (cnt_reg != len_reg)
              begin
                tx_valid_o <= 1'b1;
                tx_data_o <= mem[upt_reg[AW-1:0]];
                tx_last_o <= (cnt_reg == len_reg - PW'(1));
                upt_reg <= upt_reg + PW'(1);
                cnt_reg <= cnt_reg + PW'(1);
              end
              else
              begin
                tx_valid_o <= 1'b0;
                tx_last_o <= 1'b0;
                state_reg <= S_TXW;
                if (is_iso)
                begin
                  bnd_reg <= upt_reg;
                  ev_reg[ST_PKT_TX] <= 1'b1;
                  ev_reg[ST_IN_ACK] <= 1'b1;
                  in_ok_reg <= 1'b1;
                  sent_reg <= len_reg;
                  state_reg <= S_IDLE;
                end
              end
            end
          end
          S_TXW:
          begin
            if (hs_ack_i)
            begin
              bnd_reg <= upt_reg;
              tgl_reg <= !tgl_reg;
              ev_reg[ST_PKT_TX] <= 1'b1;
              ev_reg[ST_IN_ACK] <= 1'b1;
              in_ok_reg <= 1'b1;
              sent_reg <= len_reg;
              state_reg <= S_IDLE;
            end
            else if (hs_tmo_i)
            begin
              // Boundary stays put, so the next IN token resends the same bytes
              ev_reg[ST_TIMEOUT] <= 1'b1;
              if (int_tgl)
                tgl_reg <= !tgl_reg;
              state_reg <= S_IDLE;
            end
          end
          default: state_reg <= S_IDLE;
        endcase
      end
    end
  end
endmodule : une_engine
`default_nettype wire

// ---- une_engine_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none
module une_engine_monitor
  import une_pkg::*;
(
  // Clock, enable and reset
  input wire logic mclk_i,
  input wire logic ce_i,
  input wire logic rst_i,
  // Watched ports
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic we_i,
  input wire logic tok_out_i,
  input wire logic tok_in_i,
  input wire logic tok_ping_i,
  input wire logic rx_end_i,
  input wire logic hs_tmo_i,
  input wire logic resp_stb_o,
  input var une_pkg::une_resp_type resp_code_o,
  input wire logic [une_pkg::STAT_W-1:0] stat_o
);
  import une_pkg::*;
  logic [31:0] cfg_reg;
  // Shadow of the configuration, so rules can key on type, direction and halt
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      cfg_reg <= CFG_RESET;
    else if (ce_i && we_i && addr_i == ADDR_CFG)
      cfg_reg <= wdata_i;
  end
  wire logic iso = cfg_reg[1:0] == EPT_ISO;
  wire logic din = cfg_reg[CFG_DIR_BIT];
  wire logic halt = cfg_reg[CFG_HALT_BIT];
  wire logic nak_out = !din && resp_stb_o && resp_code_o == RSP_NAK;
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (rst_i || !ce_i);
  sequence s_ans(une_resp_type c);
    ##1 resp_stb_o && resp_code_o == c;
  endsequence
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_OUT_TOK: assert property (tok_out_i && !din |-> ##2 stat_o[ST_OUT_TOK])
    else $error("out token flag missing");
  AST_ISO_NO_HS: assert property (iso && resp_stb_o |-> resp_code_o inside {RSP_DATA, RSP_ZLP})
    else $error("iso handshake sent");
  AST_OUT_STALL: assert property (!iso && !din && halt && rx_end_i |-> s_ans(RSP_STALL))
    else $error("halted OUT not stalled");
  AST_IN_STALL: assert property (!iso && din && halt && tok_in_i |-> s_ans(RSP_STALL))
    else $error("halted IN not stalled");
  // A NAK to PING sets no OUT NAK bit, so only a NAK that ends a packet counts
  AST_NAK_FLAG: assert property (nak_out && $past(rx_end_i) |=> stat_o[ST_OUT_NAK])
    else $error("OUT NAK flag missing");
  AST_NAK_NO_RX: assert property (nak_out && !stat_o[ST_PKT_RX] |-> !stat_o[ST_PKT_RX] [*3])
    else $error("received flag after NAK");
  AST_TMO_NO_TX: assert property (!iso && din && hs_tmo_i && !stat_o[ST_PKT_TX] |-> !stat_o[ST_PKT_TX] [*3])
    else $error("sent flag after timeout");
  AST_INT_PING: assert property (cfg_reg[1:0] == EPT_INTR && tok_ping_i |=> !resp_stb_o)
    else $error("ping answered");
endmodule : une_engine_monitor
bind une_engine une_engine_monitor mon (.mclk_i(mclk_i), .ce_i(ce_i), .rst_i(rst_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .we_i(we_i), .tok_out_i(tok_out_i), .tok_in_i(tok_in_i), .tok_ping_i(tok_ping_i),
  .rx_end_i(rx_end_i), .hs_tmo_i(hs_tmo_i), .resp_stb_o(resp_stb_o), .resp_code_o(resp_code_o), .stat_o(stat_o));
`default_nettype wire

// ---- une_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module une_host_model
  import une_pkg::*;
(
  // Clock
  input wire logic mclk_i,
  // Host to device
  output logic tok_out_o,
  output logic tok_in_o,
  output logic tok_ping_o,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic rx_end_o,
  output logic rx_err_o,
  output logic rx_pid1_o,
  output logic tx_ready_o,
  output logic hs_ack_o,
  output logic hs_tmo_o,
  // Device to host
  input wire logic resp_stb_i,
  input var une_pkg::une_resp_type resp_code_i,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_last_i
);
  logic [7:0] sent[$];
  logic [7:0] got[$];
  une_resp_type rsp = RSP_ACK;
  int n_end = 0;
  int n_rsp = 0;
  initial
  begin
    {tok_out_o, tok_in_o, tok_ping_o, rx_valid_o, rx_end_o, rx_err_o} = 6'h00;
    {rx_pid1_o, hs_ack_o, hs_tmo_o} = 3'h0;
    rx_data_o = 8'hA5;
  end
  // Random pace, so the device sees both prompt and stalled takes
  always @(posedge mclk_i)
  begin
    tx_ready_o <= ($urandom % 3) != 0;
    if (resp_stb_i)
    begin
      rsp <= resp_code_i;
      n_rsp <= n_rsp + 1;
    end
    if (tx_valid_i && tx_ready_o)
      got.push_back(tx_data_i);
    if ((resp_stb_i && resp_code_i != RSP_DATA) || (tx_valid_i && tx_ready_o && tx_last_i))
      n_end <= n_end + 1;
  end
  // ----------------------------------------
  // Transfers
  // ----------------------------------------
  task automatic out_pkt(input int n, input logic err, input logic pid1);
    logic [7:0] b = 8'h5A;
    @(posedge mclk_i);
    tok_out_o <= 1'b1;
    @(posedge mclk_i);
    tok_out_o <= 1'b0;
    for (int i = 0; i < n; i++)
    begin
      b = 8'($urandom);
      sent.push_back(b);
      rx_valid_o <= 1'b1;
      rx_data_o <= b;
      @(posedge mclk_i);
    end
    rx_valid_o <= 1'b0;
    rx_data_o <= ~b;
    rx_end_o <= 1'b1;
    rx_err_o <= err;
    rx_pid1_o <= pid1;
    @(posedge mclk_i);
    rx_end_o <= 1'b0;
    rx_err_o <= 1'b0;
    repeat (3) @(posedge mclk_i);
  endtask : out_pkt
  // hs: 0 no handshake, 1 ACK, 2 timeout
  task automatic in_pkt(input int hs);
    int m;
    // Count of finished answers, so the wait ends on this transfer's own end
    m = n_end;
    @(posedge mclk_i);
    tok_in_o <= 1'b1;
    @(posedge mclk_i);
    tok_in_o <= 1'b0;
    for (int i = 0; i < 3000 && n_end == m; i++)
      @(posedge mclk_i);
    repeat (2) @(posedge mclk_i);
    hs_ack_o <= hs == 1;
    hs_tmo_o <= hs == 2;
    @(posedge mclk_i);
    hs_ack_o <= 1'b0;
    hs_tmo_o <= 1'b0;
    repeat (3) @(posedge mclk_i);
  endtask : in_pkt
  task automatic ping();
    @(posedge mclk_i);
    tok_ping_o <= 1'b1;
    @(posedge mclk_i);
    tok_ping_o <= 1'b0;
    repeat (3) @(posedge mclk_i);
  endtask : ping
endmodule : une_host_model
`default_nettype wire

// ---- une_pkg.sv ----
package une_pkg;
  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_XFER = 8'h08;
  localparam logic [7:0] ADDR_DATA = 8'h0C;
  localparam logic [7:0] ADDR_AVAIL = 8'h10;
  // ----------------------------------------
  // Configuration fields
  // ----------------------------------------
  localparam int CFG_TYPE_LSB = 0;
  localparam int CFG_DIR_BIT = 2;
  localparam int CFG_IMODE_BIT = 3;
  localparam int CFG_HALT_BIT = 4;
  localparam int CFG_NAKO_BIT = 5;
  localparam int CFG_TGL_BIT = 8;
  localparam int CFG_MPS_LSB = 16;
  localparam int MPS_W = 11;
  localparam logic [31:0] CFG_RESET = 32'h0200_0001;
  localparam logic [1:0] EPT_ISO = 2'h0;
  localparam logic [1:0] EPT_BULK = 2'h1;
  localparam logic [1:0] EPT_INTR = 2'h2;
  // ----------------------------------------
  // Status bits, write one to clear
  // ----------------------------------------
  localparam int ST_OUT_TOK = 0;
  localparam int ST_IN_TOK = 1;
  localparam int ST_PKT_RX = 2;
  localparam int ST_PKT_TX = 3;
  localparam int ST_OUT_ACK = 4;
  localparam int ST_OUT_NAK = 5;
  localparam int ST_IN_ACK = 6;
  localparam int ST_IN_NAK = 7;
  localparam int ST_TIMEOUT = 8;
  localparam int ST_OVERFLOW = 9;
  localparam int ST_UNDERFLOW = 10;
  localparam int STAT_W = 11;
  localparam int XFER_W = 24;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum {S_IDLE, S_RX, S_TX, S_TXW} une_state_type;
  typedef enum logic [2:0] {RSP_ACK, RSP_NAK, RSP_STALL, RSP_DATA, RSP_ZLP} une_resp_type;
endpackage : une_pkg
